// file: hw/timer8_pkg.sv
// Purpose: shared constants and carriers of the 8-bit timer with shared prescaler
// Assumes: APB register access, four clocks of one quarter phase each per instruction cycle
// Notes: offsets are byte addresses of aligned 32-bit words
package timer8_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] COUNT_OFS = 8'h00;
    localparam logic [7:0] CONFIG_OFS = 8'h04;
    localparam logic [7:0] IRQCTL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CFG_RATE_LSB = 0;
    localparam int CFG_RATE_W = 3;
    localparam int CFG_ASSIGN_BIT = 3;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_SRC_BIT = 5;
    localparam int CFG_ALT_BIT = 6;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [6:0] CONFIG_RST = 7'h00;
    localparam logic [7:0] COUNT_WRAP = 8'hff;
    localparam logic [7:0] RATE_MASK_FULL = 8'hff;
    localparam logic [2:0] RATE_MAX = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int QUARTERS_PER_CYCLE = 4;
    localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * QUARTERS_PER_CYCLE;
    localparam logic [1:0] HOLDOFF_CYCLES = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH} phase_t;

    typedef struct packed {
        logic altSource;
        logic countSourceSelect;
        logic edgeSelect;
        logic prescalerAssign;
        logic [2:0] prescaleRate;
    } config_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apbReq_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apbRsp_t;

endpackage

// file: hw/timer8_with_shared_prescaler.sv
// Purpose: 8-bit timer/counter with a prescaler shared with the watchdog, APB registers
// Assumes: ref_clk is one quarter phase; four clocks make one instruction cycle
// Notes: the watchdog itself lives outside; it gets its tick through this block
//
// Notes on behaviour
// - In timer mode with no prescaler the count rises by one each instruction cycle.
// - A write to the count blocks increments for the next two instruction cycles.
// - In counter mode with no prescaler the count advances on each chosen edge of the chosen external source.
// - With counter mode on, the alt bit picks the clock pin at 0 and the sense osc at 1.
// - The edge bit picks rising or falling edges for either external source.
// - The prescaler serves either the timer or the watchdog; assign bit 0 means timer.
// - Assigned to the timer, the rate field picks one of eight ratios from 1:2 to 1:256.
// - A 1:1 timer rate comes only from giving the prescaler to the watchdog.
// - Software cannot see the prescaler; a count write clears it while the timer owns it.
// - With the watchdog owning it, the clear-watchdog instruction clears the prescaler.
// - Each wrap of the count from FFh to 00h sets the overflow flag regardless of enable.
// - The interrupt is raised only when the flag and its enable are both set.
// - Hardware never clears the flag; software clears it by writing the flag bit as zero.
// - In sleep the count is frozen, so no overflow and no wake by this timer.
// - In counter mode the prescaler output is sampled in the second and fourth quarters.
`timescale 1ns/1ps

module timer8_with_shared_prescaler (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire timer8_pkg::apbReq_t apbReq,
    output timer8_pkg::apbRsp_t apbRsp,
    input wire logic extClockPin,
    input wire logic capSenseOsc,
    input wire logic sleepMode,
    input wire logic clearWatchdogInstr,
    input wire logic watchdogTickIn,
    output logic watchdogTickOut,
    output logic timerIrq
);
    import timer8_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rstSync_q;
    logic rstn;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstn = rstSync_q[1];

    // ****************************************
    // state
    // ****************************************
    phase_t phase_q, phase_d;
    logic [7:0] count_q;
    logic [7:0] prescale_q;
    logic [1:0] holdoff_q;
    logic pending_q;
    logic flag_q;
    logic irqEnable_q;
    config_t cfg_q;
    logic [1:0] pinSync_q;
    logic [1:0] oscSync_q;
    logic srcLevel_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;
    logic wdtTick_q;

    // ****************************************
    // quarter phase sequencer
    // ****************************************
    always_comb begin
        unique case (phase_q)
            PH_FIRST: phase_d = PH_SECOND;
            PH_SECOND: phase_d = PH_THIRD;
            PH_THIRD: phase_d = PH_FOURTH;
            PH_FOURTH: phase_d = PH_FIRST;
        endcase
    end

    wire cycleEnd = (phase_q == PH_FOURTH);
    wire syncSlot = (phase_q == PH_SECOND) || (phase_q == PH_FOURTH);

    // ****************************************
    // apb decode
    // ****************************************
    wire apbAccess = apbReq.psel && apbReq.penable;
    wire apbDone = apbAccess && pready_q;
    wire hitCount = (apbReq.paddr == COUNT_OFS);
    wire hitConfig = (apbReq.paddr == CONFIG_OFS);
    wire hitIrq = (apbReq.paddr == IRQCTL_OFS);
    wire hitStatus = (apbReq.paddr == STATUS_OFS);
    wire hitAny = hitCount || hitConfig || hitIrq || hitStatus;
    wire wrStrobe = apbDone && apbReq.pwrite;
    wire wrCount = wrStrobe && hitCount;
    wire wrConfig = wrStrobe && hitConfig;
    wire wrIrq = wrStrobe && hitIrq;

    // ****************************************
    // external source selection and edges
    // ****************************************
    wire timerOwnsPre = !cfg_q.prescalerAssign;
    wire counterMode = cfg_q.countSourceSelect;
    wire extRaw = cfg_q.altSource ? oscSync_q[1] : pinSync_q[1];
    wire srcLevel = extRaw ^ cfg_q.edgeSelect;
    wire extEdge = srcLevel && !srcLevel_q;

    // ****************************************
    // shared prescaler
    // ****************************************
    wire [7:0] rateMask = RATE_MASK_FULL >> (RATE_MAX - cfg_q.prescaleRate);
    wire timerSrcTick = counterMode ? extEdge : cycleEnd;
    // in sleep the timer side of the prescaler stops too, so nothing piles up
    wire preInTick = timerOwnsPre ? (timerSrcTick && !sleepMode) : watchdogTickIn;
    wire preTerminal = ((prescale_q & rateMask) == rateMask);
    wire preOutTick = preInTick && preTerminal;
    wire preClear = (timerOwnsPre && wrCount) || (!timerOwnsPre && clearWatchdogInstr);
    wire timerTick = timerOwnsPre ? preOutTick : timerSrcTick;
    wire wdtTick = timerOwnsPre ? watchdogTickIn : preOutTick;

    // ****************************************
    // increment decision
    // ****************************************
    wire holdoffActive = (holdoff_q != 2'h0);
    wire cntModeInc = counterMode && (pending_q || timerTick) && syncSlot;
    wire tmrModeInc = !counterMode && timerTick;
    wire incCount = (cntModeInc || tmrModeInc) && !holdoffActive && !sleepMode;
    wire overflowEv = incCount && (count_q == COUNT_WRAP) && !wrCount;

    // ****************************************
    // register read mux
    // ****************************************
    wire [31:0] cfgWord = {25'h000_0000, cfg_q};
    wire [31:0] irqWord = {30'h0000_0000, irqEnable_q, flag_q};
    wire [31:0] statusWord = {27'h000_0000, holdoff_q, phase_q, pending_q};
    wire [31:0] readWord = hitCount ? {24'h00_0000, count_q} :
                           hitConfig ? cfgWord :
                           hitIrq ? irqWord :
                           hitStatus ? statusWord : 32'h0000_0000;

    // ****************************************
    // next values
    // ****************************************
    wire flagCleared = wrIrq && !apbReq.pwdata[IRQ_FLAG_BIT];
    wire flag_d = overflowEv || (flag_q && !flagCleared);
    wire [7:0] count_d = wrCount ? apbReq.pwdata[7:0] :
                         incCount ? 8'(count_q + 8'h01) : count_q;
    wire [7:0] prescale_d = preClear ? 8'h00 :
                            preInTick ? 8'(prescale_q + 8'h01) : prescale_q;
    wire [1:0] holdoff_d = wrCount ? HOLDOFF_CYCLES :
                           (holdoffActive && cycleEnd) ? 2'(holdoff_q - 2'h1) : holdoff_q;
    // counter edges wait here for the next sampling quarter
    wire pending_d = (wrCount || !counterMode) ? 1'b0 :
                     (cntModeInc && !holdoffActive && !sleepMode) ? 1'b0 :
                     (pending_q || timerTick);
    wire irq_d = flag_d && irqEnable_q;

    // ****************************************
    // synchronisers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinSync_q <= 2'h0;
            oscSync_q <= 2'h0;
        end else begin
            pinSync_q <= {pinSync_q[0], extClockPin};
            oscSync_q <= {oscSync_q[0], capSenseOsc};
        end
    end

    // ****************************************
    // timer core
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= PH_FIRST;
            srcLevel_q <= 1'b0;
            count_q <= COUNT_RST;
            prescale_q <= 8'h00;
            holdoff_q <= 2'h0;
            pending_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            srcLevel_q <= srcLevel;
            count_q <= count_d;
            prescale_q <= prescale_d;
            holdoff_q <= holdoff_d;
            pending_q <= pending_d;
        end
    end

    // ****************************************
    // registers and interrupt
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= CONFIG_RST;
            irqEnable_q <= 1'b0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            wdtTick_q <= 1'b0;
        end else begin
            if (wrConfig) begin
                cfg_q <= apbReq.pwdata[6:0];
            end
            if (wrIrq) begin
                irqEnable_q <= apbReq.pwdata[IRQ_EN_BIT];
            end
            flag_q <= flag_d;
            irq_q <= irq_d;
            wdtTick_q <= wdtTick;
        end
    end

    // ****************************************
    // apb response, one wait state per access
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apbAccess && !pready_q;
            pslverr_q <= apbAccess && !pready_q && !hitAny;
            prdata_q <= (apbAccess && !pready_q && !apbReq.pwrite) ? readWord : 32'h0000_0000;
        end
    end

    assign apbRsp.pready = pready_q;
    assign apbRsp.pslverr = pslverr_q;
    assign apbRsp.prdata = prdata_q;
    assign timerIrq = irq_q;
    assign watchdogTickOut = wdtTick_q;

endmodule

// file: verification/timer8_with_shared_prescaler_properties.sv
// Purpose: port-level checks of the 8-bit timer with shared prescaler
// Assumes: one wait state on APB; config and enable shadowed from bus writes
// Notes: count and flag are inside the block, so only their effects are seen
`timescale 1ns/1ps
module timer8_props import timer8_pkg::*; (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire timer8_pkg::apbReq_t apbReq,
    input wire timer8_pkg::apbRsp_t apbRsp,
    input wire logic extClockPin,
    input wire logic capSenseOsc,
    input wire logic sleepMode,
    input wire logic clearWatchdogInstr,
    input wire logic watchdogTickIn,
    input wire logic watchdogTickOut,
    input wire logic timerIrq
);
    logic presAssign_q;
    logic irqEn_q;
    wire wrDone = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
    wire mapped = apbReq.paddr inside {COUNT_OFS, CONFIG_OFS, IRQCTL_OFS, STATUS_OFS};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // shadows follow the bus, not the block, so a stuck register inside still shows
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            presAssign_q <= 1'b0;
            irqEn_q <= 1'b0;
        end else if (wrDone) begin
            if (apbReq.paddr == CONFIG_OFS) presAssign_q <= apbReq.pwdata[CFG_ASSIGN_BIT];
            if (apbReq.paddr == IRQCTL_OFS) irqEn_q <= apbReq.pwdata[IRQ_EN_BIT];
        end
    end
    a_ready_one_wait: assert property ($rose(apbReq.penable) && apbReq.psel
        |-> !apbRsp.pready ##1 apbRsp.pready) else $error("pready not one wait state");
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (apbRsp.pready && !mapped
        |-> apbRsp.pslverr && apbRsp.prdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property (apbRsp.pready && mapped |-> !apbRsp.pslverr)
        else $error("mapped access refused");
    a_idle_data: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
        else $error("read data outside answer");
    a_count_width: assert property (
        apbRsp.pready && !apbReq.pwrite && apbReq.paddr == COUNT_OFS
        |-> apbRsp.prdata[31:8] == 24'h0) else $error("count wider than 8 bits");
    a_tick_bypass: assert property (
        !presAssign_q && !$past(presAssign_q) |-> watchdogTickOut == $past(watchdogTickIn))
        else $error("watchdog tick not passed raw");
    a_irq_enable: assert property ($rose(timerIrq) |-> irqEn_q)
        else $error("interrupt without enable");
    c_refused: cover property (apbRsp.pslverr);
    c_irq: cover property ($rose(timerIrq));
    c_wd_tick: cover property (watchdogTickOut && presAssign_q);
endmodule
bind timer8_with_shared_prescaler timer8_props u_props (.ref_clk, .resetn, .apbReq, .apbRsp,
    .extClockPin, .capSenseOsc, .sleepMode, .clearWatchdogInstr, .watchdogTickIn,
    .watchdogTickOut, .timerIrq);

// file: verification/ext_source_model.sv
// Purpose: far-side sources for counter mode, clock pin and sense oscillator
// Assumes: each line toggles once a half period while its go input is high
// Notes: a line stands still at its last level when go falls, as a real pin would
`timescale 1ns/1ps
module ext_source_model #(
    parameter int PIN_HALF_NS = 500,
    parameter int OSC_HALF_NS = 300
) (
    input wire logic goPin,
    input wire logic goOsc,
    output logic extClockPin,
    output logic capSenseOsc
);
    initial extClockPin = 1'b0;
    initial capSenseOsc = 1'b0;
    always begin
        wait (goPin);
        #(PIN_HALF_NS);
        if (goPin) extClockPin = ~extClockPin;
    end
    always begin
        wait (goOsc);
        #(OSC_HALF_NS);
        if (goOsc) capSenseOsc = ~capSenseOsc;
    end
endmodule

// file: verification/timer8_with_shared_prescaler_tb_top.sv
// Purpose: self-checking bench of the 8-bit timer with shared prescaler
// Assumes: APB answers after one wait state; sources toggle only when asked
// Notes: timer counts are checked in a window, the write phase is not pinned
`timescale 1ns/1ps
module timer8_with_shared_prescaler_tb_top;
    import timer8_pkg::*;
    typedef struct {logic rd; logic [31:0] want; logic [7:0] span; logic err;} note_t;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic sleepMode = 1'b0, clearWatchdogInstr = 1'b0, watchdogTickIn = 1'b0;
    logic manTick = 1'b0, randOn = 1'b0, goPin = 1'b0, goOsc = 1'b0, en;
    logic extClockPin, capSenseOsc, watchdogTickOut, timerIrq;
    apbReq_t apbReq = '0;
    apbRsp_t apbRsp;
    note_t q[$];
    note_t n;
    int error_cnt = 0, n_tests = 0, wdOut = 0, base, ratio;
    int seed = 32'hd2a9;
    logic [6:0] cfg;
    logic [7:0] rel, exp8;
    timer8_with_shared_prescaler dut (.ref_clk, .resetn, .apbReq, .apbRsp, .extClockPin,
        .capSenseOsc, .sleepMode, .clearWatchdogInstr, .watchdogTickIn, .watchdogTickOut,
        .timerIrq);
    ext_source_model src (.goPin, .goOsc, .extClockPin, .capSenseOsc);
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) watchdogTickIn <= manTick | (randOn & ($random(seed) % 5 == 0));
    always @(posedge ref_clk) if (watchdogTickOut === 1'b1) wdOut++;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    // for reads d is the expected value; the answer may land up to span above it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [7:0] sp);
        q.push_back('{!w, d, sp, !(a inside {COUNT_OFS, CONFIG_OFS, IRQCTL_OFS, STATUS_OFS})});
        @(posedge ref_clk);
        apbReq <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    task automatic pulse(input bit isClr);
        @(posedge ref_clk);
        if (isClr) clearWatchdogInstr <= 1'b1; else manTick <= 1'b1;
        @(posedge ref_clk);
        clearWatchdogInstr <= 1'b0;
        manTick <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1) begin
            n = q.pop_front();
            check("slverr", {31'h0, apbRsp.pslverr}, {31'h0, n.err});
            rel = apbRsp.prdata[7:0] - n.want[7:0];
            if (n.rd) check("rdata", (rel <= n.span && apbRsp.prdata[31:8] === n.want[31:8])
                ? n.want : apbRsp.prdata, n.want);
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #6000000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(0, CONFIG_OFS, 32'h0, 0);
        apb(0, IRQCTL_OFS, 32'h0, 0);
        apb(0, 8'h10, 32'h0, 0);
        apb(1, 8'h14, 32'h5, 0);
        cfg = 7'($random(seed));
        apb(1, CONFIG_OFS, {25'h0, cfg}, 0);
        apb(0, CONFIG_OFS, {25'h0, cfg}, 0);
        $display("test registers done");
        randOn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            ratio = (i < 8) ? (2 << i) : 1;
            en = i[0];
            apb(1, CONFIG_OFS, (i < 8) ? i : 32'h0f, 0);
            // enable must be set before the wrap, or the irq check sees the last loop's enable
            apb(1, IRQCTL_OFS, {30'h0, en, 1'b0}, 0);
            apb(1, COUNT_OFS, 32'hf8, 0);
            apb(0, COUNT_OFS, 32'hf8, 0);
            repeat (48 * ratio) @(posedge ref_clk);
            apb(0, COUNT_OFS, 32'h01, 4);
            apb(0, IRQCTL_OFS, {30'h0, en, 1'b1}, 0);
            check("irq", {31'h0, timerIrq}, {31'h0, en});
            apb(1, IRQCTL_OFS, {30'h0, en, 1'b0}, 0);
            apb(0, IRQCTL_OFS, {30'h0, en, 1'b0}, 0);
            // the irq output is registered, let its update settle before looking
            @(posedge ref_clk);
            check("irq", {31'h0, timerIrq}, 32'h0);
        end
        $display("test rates done");
        apb(1, COUNT_OFS, 32'h33, 0);
        sleepMode <= 1'b1;
        repeat (200) @(posedge ref_clk);
        apb(0, COUNT_OFS, 32'h33, 0);
        sleepMode <= 1'b0;
        $display("test sleep done");
        for (int k = 0; k < 4; k++) begin
            apb(1, CONFIG_OFS, {25'h0, k[1], 1'b1, k[0], 4'h8}, 0);
            apb(1, COUNT_OFS, 32'h0, 0);
            repeat (12) @(posedge ref_clk);
            exp8 = k[1] ? 8'h04 : ((k[0] == extClockPin) ? 8'h03 : 8'h02);
            goPin <= 1'b1;
            goOsc <= 1'b1;
            repeat (26) @(posedge ref_clk);
            goPin <= 1'b0;
            goOsc <= 1'b0;
            repeat (12) @(posedge ref_clk);
            apb(0, COUNT_OFS, {24'h0, exp8}, 0);
        end
        $display("test counter done");
        randOn <= 1'b0;
        apb(1, CONFIG_OFS, 32'h08, 0);
        pulse(1);
        base = wdOut;
        pulse(0);
        pulse(1);
        pulse(0);
        check("wdtick", 32'(wdOut - base), 32'h0);
        pulse(0);
        check("wdtick", 32'(wdOut - base), 32'h1);
        $display("test watchdog done");
        test_done();
    end
endmodule
